// ===== bench/tws_master_model.sv
`default_nettype none
module tws_master_model (
  input  wire logic sclLine,
  input  wire logic sdaLine,
  output var  logic sclLow,
  output var  logic sdaLow
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclLow = 1'h0;
    sdaLow = 1'h0;
  end
  // Data moves only well inside the low phase, so no false start or stop is seen.
  task automatic sendBit(input logic b, output logic seen);
    #20 sdaLow = ~b;
    #60 sclLow = 1'h0;
    wait (sclLine);
    seen = sdaLine;
    #80 sclLow = 1'h1;
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sendBit(d[i], s);
    end
    sendBit(1'h1, s);
    ack = ~s;
  endtask
  task automatic startCond();
    #80 sdaLow = 1'h1;
    #80 sclLow = 1'h1;
  endtask
  task automatic stopCond();
    #20 sdaLow = 1'h1;
    #60 sclLow = 1'h0;
    wait (sclLine);
    #80 sdaLow = 1'h0;
    #80;
  endtask
endmodule // tws_master_model
`default_nettype wire

// ===== bench/tws_slave_rx_checker.sv
`default_nettype none
module tws_slave_rx_checker (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       ce,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic       sclIn,
  input wire logic       sclOut,
  input wire logic       sclOe,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       sleepMode,
  input wire logic       wakeReq,
  input wire logic       jobDone
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ackEn;
  logic clrHit;
  assign clrHit = ce && regWr && regAddr == 2'h1 && regWdata[7];
  // Shadow of the acknowledge enable, rebuilt from control writes.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ackEn <= 1'h0;
    end else if (ce && regWr && regAddr == 2'h1) begin
      ackEn <= regWdata[6];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence ackHold;
    sdaOe [*8];
  endsequence
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data seen outside its cycle");
  a_lines_low: assert property (sclOut == 1'h0 && sdaOut == 1'h0)
    else $error("line outputs not zero");
  a_ack_needs_en: assert property ($rose(sdaOe) |-> ackEn)
    else $error("acknowledge while disabled");
  a_ack_width: assert property ($rose(sdaOe) |-> ackHold)
    else $error("acknowledge too short");
  a_ack_release: assert property (sdaOe && $fell(sclIn) |-> ##[1:6] !sdaOe)
    else $error("acknowledge not released");
  a_stretch_hold: assert property (jobDone && sclOe && !clrHit |=> sclOe)
    else $error("clock released before clear");
  a_stretch_free: assert property ($fell(jobDone) |=> !sclOe)
    else $error("clock held after clear");
  a_clear_done: assert property (jobDone && sclOe && clrHit |=> !jobDone)
    else $error("done flag not cleared");
  a_wake_cause: assert property ($rose(wakeReq) |-> $past(sleepMode))
    else $error("wake without sleep");
  a_wake_drop: assert property (!$past(sleepMode) |-> !wakeReq)
    else $error("wake held while awake");
endmodule // tws_slave_rx_checker
bind tws_slave_rx tws_slave_rx_checker i_tws_slave_rx_checker (
  .clk(clk), .sys_rst(sys_rst), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sclIn(sclIn), .sclOut(sclOut),
  .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .sleepMode(sleepMode),
  .wakeReq(wakeReq), .jobDone(jobDone)
);
`default_nettype wire

// ===== bench/tws_slave_rx_test.sv
`default_nettype none
module tws_slave_rx_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk;
  logic       sys_rst;
  logic [1:0] regAddr;
  logic [7:0] regWdata;
  logic       regWr;
  logic       regRd;
  logic       sleepMode;
  logic       arbLost;
  logic       ce;
  logic       ack;
  logic [7:0] rd;
  wire  logic [7:0] regRdata;
  wire  logic sclOut, sclOe, sdaOut, sdaOe, wakeReq, jobDone, sclLow, sdaLow;
  wire  logic sclLine = ~(sclOe | sclLow);
  wire  logic sdaLine = ~(sdaOe | sdaLow);
  int errCount = 0;
  int checked = 0;
  int cycles = 0;
  tws_slave_rx i_tws_slave_rx (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sclIn(sclLine), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .sleepMode(sleepMode),
    .arbLost(arbLost), .wakeReq(wakeReq), .jobDone(jobDone)
  );
  tws_master_model i_tws_master_model (
    .sclLine(sclLine), .sdaLine(sdaLine), .sclLow(sclLow), .sdaLow(sdaLow)
  );
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic finishTest();
    if (errCount == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic regWrite(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
  endtask
  task automatic regRead(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    #1 check(regRdata, exp);
  endtask
  // Prescaler bits hold 2 after the reset scenario, so each code carries them.
  task automatic waitBit(input logic expAck, input logic done, input logic [7:0] st);
    check({7'h00, ack}, {7'h00, expAck});
    repeat (8) @(posedge clk);
    check({7'h00, jobDone}, {7'h00, done});
    if (done) regRead(2'h2, st | 8'h02);
  endtask
  task automatic addrByte(input logic [7:0] b, input logic expAck, input logic [7:0] st);
    i_tws_master_model.startCond();
    i_tws_master_model.sendByte(b, ack);
    waitBit(expAck, expAck, st);
  endtask
  task automatic dataByte(input logic [7:0] c, input logic [7:0] d, input logic expAck,
                          input logic [7:0] st);
    regWrite(2'h1, c);
    i_tws_master_model.sendByte(d, ack);
    waitBit(expAck, 1'h1, st);
  endtask
  task automatic endXfer();
    regWrite(2'h1, 8'hC4);
    i_tws_master_model.stopCond();
    repeat (8) @(posedge clk);
    regRead(2'h2, 8'hA2);
    regWrite(2'h1, 8'hC4);
  endtask
  task automatic tReset();
    regRead(2'h0, 8'hFE);
    regRead(2'h1, 8'h00);
    regRead(2'h2, 8'hF8);
    regRead(2'h3, 8'hFF);
    regWrite(2'h2, 8'h02);
    regRead(2'h2, 8'hFA);
    regWrite(2'h3, 8'h11);
    regRead(2'h1, 8'h08);
  endtask
  // A write while the clock enable is low must leave the register untouched.
  task automatic tFreeze();
    @(posedge clk);
    ce <= 1'h0;
    regWrite(2'h0, 8'h12);
    ce <= 1'h1;
    regRead(2'h0, 8'hFE);
  endtask
  task automatic tOwnAddr();
    regWrite(2'h0, 8'h55);
    regWrite(2'h1, 8'h44);
    addrByte(8'h54, 1'h1, 8'h60);
    dataByte(8'hC4, 8'hA5, 1'h1, 8'h80);
    regRead(2'h3, 8'hA5);
    dataByte(8'h84, 8'h3C, 1'h0, 8'h88);
    regWrite(2'h1, 8'h84);
    i_tws_master_model.stopCond();
    addrByte(8'h54, 1'h0, 8'h00);
    i_tws_master_model.stopCond();
  endtask
  task automatic tAckOff();
    regWrite(2'h1, 8'h44);
    addrByte(8'h55, 1'h0, 8'h00);
    i_tws_master_model.stopCond();
    addrByte(8'h54, 1'h1, 8'h60);
    endXfer();
  endtask
  task automatic tGenCall();
    addrByte(8'h00, 1'h1, 8'h70);
    dataByte(8'hC4, 8'h5A, 1'h1, 8'h90);
    endXfer();
    regWrite(2'h0, 8'h54);
    addrByte(8'h00, 1'h0, 8'h00);
    i_tws_master_model.stopCond();
  endtask
  task automatic tArbLost(input logic [7:0] oar, input logic [7:0] b, input logic [7:0] st);
    regWrite(2'h0, oar);
    @(posedge clk);
    arbLost <= 1'h1;
    @(posedge clk);
    arbLost <= 1'h0;
    addrByte(b, 1'h1, st);
    endXfer();
  endtask
  task automatic tSleep();
    @(posedge clk);
    sleepMode <= 1'h1;
    addrByte(8'h54, 1'h1, 8'h60);
    check({7'h00, wakeReq}, 8'h01);
    repeat (40) @(posedge clk);
    check({7'h00, sclOe}, 8'h01);
    dataByte(8'hC4, 8'h77, 1'h1, 8'h80);
    regRead(2'h3, 8'h5A);
    check({7'h00, sclOe}, 8'h01);
    sleepMode <= 1'h0;
    repeat (3) @(posedge clk);
    check({7'h00, wakeReq}, 8'h00);
    check({7'h00, sclOe}, 8'h01);
    endXfer();
    check({7'h00, sclOe}, 8'h00);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errCount++;
      finishTest();
    end
  end
  initial begin
    sys_rst = 1'h1;
    regAddr = 2'h0;
    regWdata = 8'h00;
    regWr = 1'h0;
    regRd = 1'h0;
    sleepMode = 1'h0;
    arbLost = 1'h0;
    ce = 1'h1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (4) @(posedge clk);
    tReset();
    tFreeze();
    tOwnAddr();
    tAckOff();
    regWrite(2'h0, 8'h55);
    tGenCall();
    tArbLost(8'h54, 8'h54, 8'h68);
    tArbLost(8'h55, 8'h00, 8'h78);
    tSleep();
    finishTest();
  end
endmodule // tws_slave_rx_test
`default_nettype wire

// ===== common/tws_defines.vh
`ifndef TWS_DEFINES_VH
`define TWS_DEFINES_VH

// Register indices on the plain register port.
`define TWS_REG_OWN_ADDR  2'h0
`define TWS_REG_CONTROL   2'h1
`define TWS_REG_STATUS    2'h2
`define TWS_REG_DATA      2'h3

// Own-address register fields.
`define TWS_OAR_GCE       0
`define TWS_OAR_ADDR_MSB  7
`define TWS_OAR_ADDR_LSB  1

// Control register fields.
`define TWS_CR_DONE       7
`define TWS_CR_ACK_EN     6
`define TWS_CR_START      5
`define TWS_CR_STOP       4
`define TWS_CR_WCOL       3
`define TWS_CR_IFACE_EN   2
`define TWS_CR_IRQ_EN     0

// Status register fields.
`define TWS_SR_PRESC_MSB  1
`define TWS_SR_CODE_MASK  8'hF8

// Reset values.
`define TWS_OAR_RESET     8'hFE
`define TWS_CR_RESET      8'h00
`define TWS_DATA_RESET    8'hFF

// Status codes with the prescaler bits at zero.
`define TWS_ST_OWN_W      8'h60
`define TWS_ST_ARB_OWN_W  8'h68
`define TWS_ST_GC         8'h70
`define TWS_ST_ARB_GC     8'h78
`define TWS_ST_DATA_ACK   8'h80
`define TWS_ST_DATA_NACK  8'h88
`define TWS_ST_GC_ACK     8'h90
`define TWS_ST_GC_NACK    8'h98
`define TWS_ST_STOP       8'hA0
`define TWS_ST_NONE       8'hF8

// Bus addresses and bit counts.
`define TWS_GC_ADDR       8'h00
`define TWS_LAST_BIT      3'h7

`endif

// ===== design/tws_shift.v
`default_nettype none
module tws_shift (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       ce,
  input  wire       shiftEn,
  input  wire       bitIn,
  output wire [7:0] dataOut
);
  reg [7:0] shiftReg;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (sys_rst) begin
          shiftReg[i] <= 1'b0;
        end else if (ce && shiftEn) begin
          if (i == 0) begin
            shiftReg[i] <= bitIn;
          end else begin
            shiftReg[i] <= shiftReg[i-1];
          end
        end
      end
    end
  endgenerate

  assign dataOut = shiftReg;
endmodule // tws_shift
`default_nettype wire

// ===== design/tws_slave_rx.v
// Function
// (RL1) Upper seven own-address bits form slave address.
// (RL2) Low own-address bit enables general call response.
// (RL3) Software enables interface and ack before reception.
// (RL4) Match address; direction zero selects slave receive.
// (RL5) Own address write sets done flag, status.
// (RL6) Addressed after lost arbitration reports 0x68/0x78.
// (RL7) Ack enable cleared gives not-acknowledge next byte.
// (RL8) Ack enable zero ignores address, resumes when set.
// (RL9) In deep sleep, address match acks and wakes.
// (RL10) Clock held low after wake until flag cleared.
// (RL11) Data register not updated while asleep.
// (RL12) Status 0x60: own address write acknowledged.
// (RL13) Status 0x70: general call acknowledged.
// (RL14) Status 0x68: arbitration lost, own address acknowledged.
// (RL15) Status 0x78: arbitration lost, general call acknowledged.
// (RL16) Clearing flag receives next byte, ack per enable.
// (RL17) After 0x88 clear returns to not addressed.
// (RL18) Status codes defined with prescaler bits zero.
// (RL19) Stop or repeated start while addressed gives 0xA0.
// (RL20) Clock stretched low while done flag is set; code leaves it released when stop or start sets the flag (0xA0).
`include "tws_defines.vh"
`default_nettype none
module tws_slave_rx (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       ce,
  input  wire [1:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdata,
  input  wire       sclIn,
  output reg        sclOut,
  output reg        sclOe,
  input  wire       sdaIn,
  output reg        sdaOut,
  output reg        sdaOe,
  input  wire       sleepMode,
  input  wire       arbLost,
  output reg        wakeReq,
  output reg        jobDone
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_AACK = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;
  localparam [2:0] ST_DATA = 3'h4;
  localparam [2:0] ST_DACK = 3'h5;
  localparam [2:0] ST_SKIP = 3'h6;

  reg  [2:0] state;
  reg  [7:0] ownAddr;
  reg        ackEn;
  reg        startReq;
  reg        stopReq;
  reg        writeColl;
  reg        ifaceEn;
  reg        irqEn;
  reg  [1:0] prescale;
  reg  [7:0] statusCode;
  reg  [7:0] dataReg;
  reg  [2:0] bitCnt;
  reg        byteFull;
  reg        addressed;
  reg        gcMode;
  reg        arbFlag;
  reg        hitGc;
  reg        sclPrev;
  reg        sdaPrev;
  reg  [7:0] next_rdata;

  wire [1:0] syncOut;
  wire       sclS = syncOut[1];
  wire       sdaS = syncOut[0];
  wire [7:0] shiftData;

  wire sclRise   = sclS & ~sclPrev;
  wire sclFall   = ~sclS & sclPrev;
  wire startSeen = sclS & sclPrev & sdaPrev & ~sdaS;
  wire stopSeen  = sclS & sclPrev & ~sdaPrev & sdaS;
  wire shiftEn   = sclRise & ((state == ST_ADDR) | (state == ST_DATA));

  wire ctrlWr  = regWr & (regAddr == `TWS_REG_CONTROL);
  wire doneClr = ctrlWr & regWdata[`TWS_CR_DONE];

  // Own address match needs the write direction bit.
  wire ownHit = (shiftData[7:1] == ownAddr[`TWS_OAR_ADDR_MSB:`TWS_OAR_ADDR_LSB]) // [RL1]
                & ~shiftData[0];                                              // [RL4]
  wire gcHit  = (shiftData == `TWS_GC_ADDR) & ownAddr[`TWS_OAR_GCE];           // [RL2]
  wire addrOk = ifaceEn & ackEn & (ownHit | gcHit);                            // [RL3] [RL8]

  tws_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .din     ({sclIn, sdaIn}),
    .dout    (syncOut)
  );

  tws_shift u_shift (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .shiftEn (shiftEn),
    .bitIn   (sdaS),
    .dataOut (shiftData)
  );

  always @* begin
    case (regAddr)
      `TWS_REG_OWN_ADDR: next_rdata = ownAddr;
      `TWS_REG_CONTROL:  next_rdata = {jobDone, ackEn, startReq, stopReq,
                                       writeColl, ifaceEn, 1'b0, irqEn};
      // Prescaler bits share the status register with the code.
      `TWS_REG_STATUS:   next_rdata = statusCode | {6'h00, prescale}; // [RL18]
      `TWS_REG_DATA:     next_rdata = dataReg;
      default:           next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
    end else if (ce) begin
      regRdata <= regRd ? next_rdata : 8'h00;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      state      <= ST_IDLE;
      ownAddr    <= `TWS_OAR_RESET;
      ackEn      <= 1'b0;
      startReq   <= 1'b0;
      stopReq    <= 1'b0;
      writeColl  <= 1'b0;
      ifaceEn    <= 1'b0;
      irqEn      <= 1'b0;
      prescale   <= 2'h0;
      statusCode <= `TWS_ST_NONE;
      dataReg    <= `TWS_DATA_RESET;
      bitCnt     <= 3'h0;
      byteFull   <= 1'b0;
      addressed  <= 1'b0;
      gcMode     <= 1'b0;
      arbFlag    <= 1'b0;
      hitGc      <= 1'b0;
      sclPrev    <= 1'b1;
      sdaPrev    <= 1'b1;
      sclOut     <= 1'b0;
      sclOe      <= 1'b0;
      sdaOut     <= 1'b0;
      sdaOe      <= 1'b0;
      wakeReq    <= 1'b0;
      jobDone    <= 1'b0;
    end else if (ce) begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;

      // Register writes; hardware sets below take priority over clears.
      if (regWr && regAddr == `TWS_REG_OWN_ADDR) begin
        ownAddr <= regWdata;
      end
      if (ctrlWr) begin
        ackEn    <= regWdata[`TWS_CR_ACK_EN];
        startReq <= regWdata[`TWS_CR_START];
        stopReq  <= regWdata[`TWS_CR_STOP];
        ifaceEn  <= regWdata[`TWS_CR_IFACE_EN];
        irqEn    <= regWdata[`TWS_CR_IRQ_EN];
        if (regWdata[`TWS_CR_DONE]) begin
          jobDone   <= 1'b0;
          writeColl <= 1'b0;
        end
      end
      if (regWr && regAddr == `TWS_REG_STATUS) begin
        prescale <= regWdata[`TWS_SR_PRESC_MSB:0];
      end
      if (regWr && regAddr == `TWS_REG_DATA) begin
        if (jobDone) begin
          dataReg <= regWdata;
        end else begin
          writeColl <= 1'b1;
        end
      end
      if (arbLost) begin
        arbFlag <= 1'b1;
      end
      if (!sleepMode) begin
        wakeReq <= 1'b0;
      end

      if (shiftEn) begin
        bitCnt   <= bitCnt + 3'h1;
        byteFull <= (bitCnt == `TWS_LAST_BIT);
      end

      if (!ifaceEn) begin
        state     <= ST_IDLE;
        addressed <= 1'b0;
        sdaOe     <= 1'b0;
        sclOe     <= 1'b0;
      end else if (stopSeen) begin
        if (addressed) begin
          statusCode <= `TWS_ST_STOP; // [RL19]
          jobDone    <= 1'b1;
        end
        addressed <= 1'b0;
        sdaOe     <= 1'b0;
        state     <= ST_IDLE;
      end else if (startSeen) begin
        if (addressed) begin
          statusCode <= `TWS_ST_STOP; // [RL19]
          jobDone    <= 1'b1;
        end
        addressed <= 1'b0;
        sdaOe     <= 1'b0;
        bitCnt    <= 3'h0;
        byteFull  <= 1'b0;
        state     <= ST_ADDR;
      end else begin
        case (state)
          ST_IDLE: begin
            sdaOe <= 1'b0;
          end
          ST_ADDR: begin
            if (sclFall && byteFull) begin
              byteFull <= 1'b0;
              bitCnt   <= 3'h0;
              hitGc    <= gcHit & ~ownHit;
              if (addrOk) begin
                sdaOe <= 1'b1; // [RL4] [RL9]
                state <= ST_AACK;
              end else begin
                state <= ST_SKIP;
              end
            end
          end
          ST_AACK: begin
            if (sclFall) begin
              sdaOe     <= 1'b0;
              addressed <= 1'b1;
              gcMode    <= hitGc;
              // A loss reported in this same cycle stays pending for the next address.
              arbFlag   <= arbLost;
              jobDone   <= 1'b1; // [RL5]
              sclOe     <= 1'b1; // [RL20] [RL10]
              if (sleepMode) begin
                wakeReq <= 1'b1; // [RL9]
              end
              if (hitGc) begin
                statusCode <= arbFlag ? `TWS_ST_ARB_GC : `TWS_ST_GC; // [RL13] [RL15] [RL6]
              end else begin
                statusCode <= arbFlag ? `TWS_ST_ARB_OWN_W : `TWS_ST_OWN_W; // [RL12] [RL14]
              end
              state <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            if (doneClr) begin
              sclOe <= 1'b0; // [RL10]
              if (statusCode == `TWS_ST_DATA_NACK || statusCode == `TWS_ST_GC_NACK) begin
                addressed <= 1'b0; // [RL17]
                state     <= ST_IDLE;
              end else begin
                bitCnt   <= 3'h0;
                byteFull <= 1'b0;
                state    <= ST_DATA; // [RL16]
              end
            end
          end
          ST_DATA: begin
            if (sclFall && byteFull) begin
              byteFull <= 1'b0;
              bitCnt   <= 3'h0;
              // Asleep, the byte is not copied to the data register.
              if (!sleepMode) begin
                dataReg <= shiftData; // [RL11]
              end
              sdaOe <= ackEn; // [RL7] [RL16]
              hitGc <= ackEn;
              state <= ST_DACK;
            end
          end
          ST_DACK: begin
            if (sclFall) begin
              sdaOe   <= 1'b0;
              jobDone <= 1'b1;
              sclOe   <= 1'b1; // [RL20]
              if (gcMode) begin
                statusCode <= hitGc ? `TWS_ST_GC_ACK : `TWS_ST_GC_NACK;
              end else begin
                statusCode <= hitGc ? `TWS_ST_DATA_ACK : `TWS_ST_DATA_NACK; // [RL16] [RL7]
              end
              state <= ST_HOLD;
            end
          end
          ST_SKIP: begin
            sdaOe <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // tws_slave_rx
`default_nettype wire

// ===== design/tws_sync.v
`default_nettype none
module tws_sync (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       ce,
  input  wire [1:0] din,
  output wire [1:0] dout
);
  reg [1:0] stage1;
  reg [1:0] stage2;

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_bit
      // Bus lines idle high, so both stages reset to one.
      always @(posedge clk) begin
        if (sys_rst) begin
          stage1[i] <= 1'b1;
          stage2[i] <= 1'b1;
        end else if (ce) begin
          stage1[i] <= din[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign dout = stage2;
endmodule // tws_sync
`default_nettype wire
